/* File: inc/dcc_pkg.sv */
`default_nettype none
package dcc_pkg;

   // bus geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int NCMP   = 2;
   localparam int PORT_W = 8;

   // register offsets
   localparam logic [3:0] OFF_CMP1_CTRL   = 4'h0;
   localparam logic [3:0] OFF_CMP2_CTRL   = 4'h1;
   localparam logic [3:0] OFF_SHARED_CTRL = 4'h2;
   localparam logic [3:0] OFF_IRQ_FLAG    = 4'h3;
   localparam logic [3:0] OFF_IRQ_MASK    = 4'h4;
   localparam logic [3:0] OFF_IRQ_CTRL    = 4'h5;
   localparam logic [3:0] OFF_PORT        = 4'h6;
   localparam logic [3:0] OFF_ANALOG_SEL  = 4'h7;

   // comparator control register fields
   localparam int CTRL_ENABLE    = 7;
   localparam int CTRL_RESULT    = 6;
   localparam int CTRL_PIN_DRIVE = 5;
   localparam int CTRL_INVERT    = 4;
   localparam int CTRL_SPEED     = 3;
   localparam int CTRL_REF_SEL   = 2;
   localparam int CTRL_CH_HI     = 1;
   localparam int CTRL_CH_LO     = 0;
   localparam logic [7:0] CTRL_WMASK = 8'hBF;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // shared control register fields
   localparam int SHARED_MIRROR_1 = 7;
   localparam int SHARED_MIRROR_2 = 6;
   localparam int SHARED_RSEL_1   = 5;
   localparam int SHARED_RSEL_2   = 4;
   localparam logic [7:0] SHARED_RESET = 8'h00;

   // interrupt control register fields
   localparam int IRQ_CTRL_GLOBAL = 7;
   localparam int IRQ_CTRL_PERIPH = 6;
   localparam logic [7:0] IRQ_RESET = 8'h00;

   // analog select resets to all analog
   localparam logic [7:0] ANALOG_SEL_RESET = 8'hFF;

endpackage
`default_nettype wire

/* File: rtl/dcc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module dcc_sync
#(
   parameter int W = 1
)
(
   // clock and reset
   input  wire logic         clk_in,
   input  wire logic         nrst_in,
   // asynchronous inputs
   input  wire logic [W-1:0] async_in,
   // filtered level
   output logic      [W-1:0] level_out
);

   logic [W-1:0] stage1;
   logic [W-1:0] stage2;
   logic [W-1:0] stage3;

   genvar b;
   generate
      for (b = 0; b < W; b++)
      begin : g_bit
         // stage1 feeds only stage2; a change counts once 2 and 3 agree
         always_ff @(posedge clk_in)
         begin
            if (!nrst_in)
            begin
               stage1[b]    <= 1'b0;
               stage2[b]    <= 1'b0;
               stage3[b]    <= 1'b0;
               level_out[b] <= 1'b0;
            end
            else
            begin
               stage1[b] <= async_in[b];
               stage2[b] <= stage1[b];
               stage3[b] <= stage2[b];
               if (stage2[b] == stage3[b])
                  level_out[b] <= stage3[b];
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

/* File: rtl/dcc_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - disabled comparator core gives 0, so result equals the invert bit.
// - control writes clear mismatch latches first, new config applies after.
// - a result change coinciding with a control read may lose its flag.
// - an enabled comparator and its change detect keep running in sleep.
// - flag plus comparator and peripheral masks wake; global mask vectors.
// - reset clears both control registers and the shared register.
// - enable at bit 7, resets 0, 1 enables.
// - read-only result at bit 6, plus-exceeds-minus after the invert bit is applied.
// - pin driven only with pin drive, enable and direction output.
// - invert bit 4 inverts result when 1.
// - speed bit 3: 1 normal fast, 0 low power slow.
// - reference bit 2: 1 internal reference, 0 dedicated plus pin.
// - channel bits 1-0 pick one of four inverting input pins.
// - second comparator has identical control register layout and reset.
// - shared register mirrors both results for one skew-free read.
// - reading mirror bits never touches the mismatch latches.
// - port read returns 0 for pins set as analog.
// - mismatch is XOR of read latch and per-cycle latch.
// - change flag set on mismatch rising edge, not on its level.
// - mirrors at shared bits 7 and 6, read-only, reset 0.
module dcc_ctrl
   import dcc_pkg::*;
(
   // clock and reset
   input  wire logic                        clk_in,
   input  wire logic                        nrst_in,
   // register port
   input  wire logic [dcc_pkg::ADDR_W-1:0]  addr_in,
   input  wire logic [dcc_pkg::DATA_W-1:0]  wdata_in,
   input  wire logic                        wr_in,
   input  wire logic                        rd_in,
   output logic      [dcc_pkg::DATA_W-1:0]  rdata_out,
   // analog comparator cores
   input  wire logic [dcc_pkg::NCMP-1:0]    cmp_raw_in,
   output logic      [dcc_pkg::NCMP-1:0]    cmp_enable_out,
   output logic      [dcc_pkg::NCMP-1:0]    cmp_speed_sel_out,
   output logic      [dcc_pkg::NCMP-1:0]    cmp_ref_sel_out,
   output logic      [1:0]                  cmp1_neg_channel_out,
   output logic      [1:0]                  cmp2_neg_channel_out,
   output logic      [dcc_pkg::NCMP-1:0]    ref_src_sel_out,
   // result pins
   input  wire logic [dcc_pkg::NCMP-1:0]    pin_direction_in,
   output logic      [dcc_pkg::NCMP-1:0]    cmp_pin_out,
   output logic      [dcc_pkg::NCMP-1:0]    cmp_pin_oe_out,
   // digital port
   input  wire logic [dcc_pkg::PORT_W-1:0]  port_pins_in,
   // events
   output logic      [dcc_pkg::NCMP-1:0]    cmp_change_flag_out,
   output logic                             wake_out,
   output logic                             irq_out
);
   import dcc_pkg::*;

   // register state
   logic [DATA_W-1:0] ctrl [NCMP];
   logic [1:0]        ref_src_sel;
   logic [NCMP-1:0]   cmp_change_flag;
   logic [NCMP-1:0]   cmp_change_irq_mask;
   logic              periph_irq_mask;
   logic              global_irq_mask;
   logic [PORT_W-1:0] analog_sel;

   // synchronised inputs
   logic [NCMP-1:0]   res_sync;
   logic [PORT_W-1:0] port_sync;

   // per comparator datapath
   logic [NCMP-1:0]   core_out;
   logic [NCMP-1:0]   cmp_result;
   logic [NCMP-1:0]   read_latch;
   logic [NCMP-1:0]   cycle_latch;
   logic [NCMP-1:0]   mismatch;
   logic [NCMP-1:0]   mismatch_d;
   logic [NCMP-1:0]   set_flag;
   logic [NCMP-1:0]   hit_ctrl;
   logic [NCMP-1:0]   touch_ctrl;
   logic [NCMP-1:0]   next_cmp_change_flag;
   logic [NCMP-1:0]   next_pin_oe;

   // decode
   wire hit_shared    = (addr_in == OFF_SHARED_CTRL);
   wire hit_flag      = (addr_in == OFF_IRQ_FLAG);
   wire hit_mask      = (addr_in == OFF_IRQ_MASK);
   wire hit_irq_ctrl  = (addr_in == OFF_IRQ_CTRL);
   wire hit_port      = (addr_in == OFF_PORT);
   wire hit_analog    = (addr_in == OFF_ANALOG_SEL);
   wire wr_shared     = wr_in & hit_shared;
   wire wr_flag       = wr_in & hit_flag;
   wire wr_mask       = wr_in & hit_mask;
   wire wr_irq_ctrl   = wr_in & hit_irq_ctrl;
   wire wr_analog     = wr_in & hit_analog;

   // results pass four flops before use
   dcc_sync #(
      .W (NCMP)
   ) u_res_sync (
      .clk_in    (clk_in),
      .nrst_in   (nrst_in),
      .async_in  (cmp_raw_in),
      .level_out (res_sync)
   );

   dcc_sync #(
      .W (PORT_W)
   ) u_port_sync (
      .clk_in    (clk_in),
      .nrst_in   (nrst_in),
      .async_in  (port_pins_in),
      .level_out (port_sync)
   );

   genvar i;
   generate
      for (i = 0; i < NCMP; i++)
      begin : g_cmp
         localparam logic [3:0] MY_OFF = (i == 0) ? OFF_CMP1_CTRL
                                                  : OFF_CMP2_CTRL;

         assign hit_ctrl[i]   = (addr_in == MY_OFF);
         // a write reads first, so it also reloads the read latch
         assign touch_ctrl[i] = (rd_in | wr_in) & hit_ctrl[i];

         // disabled core contributes a constant low
         assign core_out[i]   = ctrl[i][CTRL_ENABLE] & res_sync[i];
         assign cmp_result[i] = core_out[i] ^ ctrl[i][CTRL_INVERT];

         assign mismatch[i]   = read_latch[i] ^ cycle_latch[i];
         // edge, not level: a standing mismatch cannot re-set the flag
         assign set_flag[i]   = mismatch[i] & ~mismatch_d[i];

         // hardware set wins over a software clear
         assign next_cmp_change_flag[i] = set_flag[i]
            | (wr_flag ? wdata_in[i] : cmp_change_flag[i]);

         assign next_pin_oe[i] = ctrl[i][CTRL_PIN_DRIVE]
                               & ctrl[i][CTRL_ENABLE]
                               & ~pin_direction_in[i];

         always_ff @(posedge clk_in)
         begin
            if (!nrst_in)
            begin
               ctrl[i]        <= CTRL_RESET;
               read_latch[i]  <= 1'b0;
               cycle_latch[i] <= 1'b0;
               mismatch_d[i]  <= 1'b0;
            end
            else
            begin
               // new enable and invert apply after the read phase
               if (wr_in && hit_ctrl[i])
                  ctrl[i] <= wdata_in & CTRL_WMASK;
               // read coinciding with a change swallows that event
               if (touch_ctrl[i])
                  read_latch[i] <= cmp_result[i];
               cycle_latch[i] <= cmp_result[i];
               mismatch_d[i]  <= mismatch[i];
            end
         end

         always_ff @(posedge clk_in)
         begin
            if (!nrst_in)
            begin
               cmp_pin_out[i]       <= 1'b0;
               cmp_pin_oe_out[i]    <= 1'b0;
               cmp_enable_out[i]    <= 1'b0;
               cmp_speed_sel_out[i] <= 1'b0;
               cmp_ref_sel_out[i]   <= 1'b0;
            end
            else
            begin
               cmp_pin_out[i]       <= cmp_result[i];
               cmp_pin_oe_out[i]    <= next_pin_oe[i];
               cmp_enable_out[i]    <= ctrl[i][CTRL_ENABLE];
               cmp_speed_sel_out[i] <= ctrl[i][CTRL_SPEED];
               cmp_ref_sel_out[i]   <= ctrl[i][CTRL_REF_SEL];
            end
         end
      end
   endgenerate

   // channel selects and reference source to the analog side
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
      begin
         cmp1_neg_channel_out <= 2'h0;
         cmp2_neg_channel_out <= 2'h0;
         ref_src_sel_out      <= 2'h0;
      end
      else
      begin
         cmp1_neg_channel_out <= ctrl[0][CTRL_CH_HI:CTRL_CH_LO];
         cmp2_neg_channel_out <= ctrl[1][CTRL_CH_HI:CTRL_CH_LO];
         ref_src_sel_out      <= ref_src_sel;
      end
   end

   // shared, interrupt and port registers
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
      begin
         ref_src_sel         <= SHARED_RESET[SHARED_RSEL_1:SHARED_RSEL_2];
         cmp_change_flag     <= 2'h0;
         cmp_change_irq_mask <= 2'h0;
         periph_irq_mask     <= IRQ_RESET[IRQ_CTRL_PERIPH];
         global_irq_mask     <= IRQ_RESET[IRQ_CTRL_GLOBAL];
         analog_sel          <= ANALOG_SEL_RESET;
      end
      else
      begin
         if (wr_shared)
            ref_src_sel <= wdata_in[SHARED_RSEL_1:SHARED_RSEL_2];
         cmp_change_flag <= next_cmp_change_flag;
         if (wr_mask)
            cmp_change_irq_mask <= wdata_in[NCMP-1:0];
         if (wr_irq_ctrl)
         begin
            periph_irq_mask <= wdata_in[IRQ_CTRL_PERIPH];
            global_irq_mask <= wdata_in[IRQ_CTRL_GLOBAL];
         end
         if (wr_analog)
            analog_sel <= wdata_in;
      end
   end

   // wake needs no global mask; vectoring does
   wire wake_req = (|(cmp_change_flag & cmp_change_irq_mask))
                 & periph_irq_mask;
   wire irq_req  = wake_req & global_irq_mask;

   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
      begin
         wake_out            <= 1'b0;
         irq_out             <= 1'b0;
         cmp_change_flag_out <= 2'h0;
      end
      else
      begin
         wake_out            <= wake_req;
         irq_out             <= irq_req;
         cmp_change_flag_out <= next_cmp_change_flag;
      end
   end

   // read views; the shared view does not touch the mismatch latches
   wire [7:0] ctrl1_view  = {ctrl[0][7], cmp_result[0], ctrl[0][5:0]};
   wire [7:0] ctrl2_view  = {ctrl[1][7], cmp_result[1], ctrl[1][5:0]};
   wire [7:0] shared_view = {cmp_result[0], cmp_result[1],
                             ref_src_sel, 4'h0};
   wire [7:0] flag_view   = {6'h00, cmp_change_flag};
   wire [7:0] mask_view   = {6'h00, cmp_change_irq_mask};
   wire [7:0] irqc_view   = {global_irq_mask, periph_irq_mask, 6'h00};
   // analog pins read low so no digital level leaks through
   wire [7:0] port_view   = port_sync & ~analog_sel;

   wire [7:0] read_mux =
        hit_ctrl[0]  ? ctrl1_view  :
        hit_ctrl[1]  ? ctrl2_view  :
        hit_shared   ? shared_view :
        hit_flag     ? flag_view   :
        hit_mask     ? mask_view   :
        hit_irq_ctrl ? irqc_view   :
        hit_port     ? port_view   :
        hit_analog   ? analog_sel  :
                       8'h00;

   // data stand one cycle after the strobe, zero otherwise
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
         rdata_out <= 8'h00;
      else if (rd_in)
         rdata_out <= read_mux;
      else
         rdata_out <= 8'h00;
   end

endmodule
`default_nettype wire

/* File: bench/dcc_analog_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dcc_analog_model
   import dcc_pkg::*;
(
   // settings from the block
   input  wire logic [NCMP-1:0] enable_in,
   input  wire logic [NCMP-1:0] ref_sel_in,
   input  wire logic [1:0]      ch1_in,
   input  wire logic [1:0]      ch2_in,
   // plus input above each minus pin
   input  wire logic [3:0]      pin_above_in,
   input  wire logic [3:0]      ref_above_in,
   // core outputs
   output logic      [NCMP-1:0] raw_out
);
   wire logic sel1;
   wire logic sel2;
   assign sel1 = ref_sel_in[0] ? ref_above_in[ch1_in] : pin_above_in[ch1_in];
   assign sel2 = ref_sel_in[1] ? ref_above_in[ch2_in] : pin_above_in[ch2_in];
   // no sleep input: cores run whenever enabled
   assign raw_out = enable_in & {sel2, sel1};
endmodule
`default_nettype wire

/* File: bench/dcc_ctrl_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module dcc_ctrl_monitor
   import dcc_pkg::*;
(
   // watched ports
   input wire logic       clk_in,
   input wire logic       nrst_in,
   input wire logic [3:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic       wr_in,
   input wire logic       rd_in,
   input wire logic [7:0] rdata_out,
   input wire logic [1:0] pin_direction_in,
   input wire logic [1:0] cmp_enable_out,
   input wire logic [1:0] cmp_speed_sel_out,
   input wire logic [1:0] cmp_ref_sel_out,
   input wire logic [1:0] cmp1_neg_channel_out,
   input wire logic [1:0] cmp_pin_oe_out,
   input wire logic [1:0] cmp_change_flag_out,
   input wire logic       wake_out,
   input wire logic       irq_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!nrst_in);
   sequence s_wr1;
      wr_in && addr_in == OFF_CMP1_CTRL;
   endsequence
   sequence s_wr2;
      wr_in && addr_in == OFF_CMP2_CTRL;
   endsequence
   // register loads on the strobe edge, outputs follow one edge later
   chk_enable_bit: assert property (
      s_wr1 |-> ##2 cmp_enable_out[0] == $past(wdata_in[7], 2))
      else $error("cmp1 enable not loaded");
   chk_second_layout: assert property (
      s_wr2 |-> ##2 cmp_enable_out[1] == $past(wdata_in[7], 2)
         && cmp_speed_sel_out[1] == $past(wdata_in[3], 2))
      else $error("cmp2 fields wrong");
   chk_field_decode: assert property (
      s_wr1 |-> ##2 cmp_speed_sel_out[0] == $past(wdata_in[3], 2)
         && cmp_ref_sel_out[0] == $past(wdata_in[2], 2)
         && cmp1_neg_channel_out == $past(wdata_in[1:0], 2))
      else $error("cmp1 fields wrong");
   // enable and drive leave the same register on the same edge
   chk_pin_gate: assert property (
      cmp_pin_oe_out[1] |-> cmp_enable_out[1]
         && !$past(pin_direction_in[1]))
      else $error("pin driven without its conditions");
   chk_flag_sticky: assert property (
      cmp_change_flag_out[0] && !(wr_in && addr_in == OFF_IRQ_FLAG)
         |=> cmp_change_flag_out[0])
      else $error("flag dropped without a write");
   chk_wake_cause: assert property (
      wake_out |-> $past(|cmp_change_flag_out))
      else $error("wake without flag");
   chk_irq_gated: assert property (
      irq_out |-> wake_out)
      else $error("irq without wake");
   chk_rdata_quiet: assert property (
      !rd_in |=> rdata_out == 8'h00)
      else $error("read data outside its cycle");
   chk_shared_low: assert property (
      rd_in && addr_in == OFF_SHARED_CTRL |=> rdata_out[3:0] == 4'h0)
      else $error("shared low bits not zero");
   chk_reset_off: assert property (disable iff (1'b0)
      !nrst_in |=> cmp_enable_out == 2'h0
         && cmp_change_flag_out == 2'h0 && !wake_out)
      else $error("reset left state");
endmodule
bind dcc_ctrl dcc_ctrl_monitor mon (.clk_in, .nrst_in, .addr_in, .wdata_in,
   .wr_in, .rd_in, .rdata_out, .pin_direction_in, .cmp_enable_out,
   .cmp_speed_sel_out, .cmp_ref_sel_out, .cmp1_neg_channel_out,
   .cmp_pin_oe_out, .cmp_change_flag_out, .wake_out, .irq_out);
`default_nettype wire

/* File: bench/dcc_ctrl_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module dcc_ctrl_bench;
   import dcc_pkg::*;
   logic       clk_in, nrst_in, wr_in, rd_in, wake, irq;
   logic [3:0] addr_in, pin_above, ref_above;
   logic [7:0] wdata_in, port_pins, rdata_out;
   logic [1:0] dir, raw, en, sp, rs, ch1, ch2, rsrc, pin, oe, flag;
   int         bad_count, check_count;
   initial
   begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   dcc_ctrl DUT (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .cmp_raw_in(raw), .cmp_enable_out(en),
      .cmp_speed_sel_out(sp), .cmp_ref_sel_out(rs),
      .cmp1_neg_channel_out(ch1), .cmp2_neg_channel_out(ch2),
      .ref_src_sel_out(rsrc), .pin_direction_in(dir), .cmp_pin_out(pin),
      .cmp_pin_oe_out(oe), .port_pins_in(port_pins),
      .cmp_change_flag_out(flag), .wake_out(wake), .irq_out(irq));
   dcc_analog_model cores (.enable_in(en), .ref_sel_in(rs), .ch1_in(ch1),
      .ch2_in(ch2), .pin_above_in(pin_above), .ref_above_in(ref_above),
      .raw_out(raw));
   task automatic summarize;
      $display("checks %0d bad %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1;
      chk(rdata_out, e);
   endtask
   task automatic above(input logic [3:0] v);
      @(posedge clk_in);
      pin_above <= v;
   endtask
   // bounded: a missing flag counts and ends the run
   task automatic wait_flag;
      int k;
      k = 0;
      #1;
      while (flag[0] !== 1'b1 && k < 20)
      begin
         cyc(1);
         k++;
      end
      chk({7'h0, flag[0]}, 8'h01);
      if (k == 20)
         summarize();
   endtask
   task automatic t_reset;
      for (int i = 0; i < 8; i++)
         rdc(4'(i), i == 7 ? 8'hFF : 8'h00);
      chk({en, flag, 4'h0}, 8'h00);
      $display("reset test done");
   endtask
   task automatic t_fields;
      for (int c = 0; c < 4; c++)
      begin
         wr(OFF_CMP1_CTRL, 8'h0C | 8'(c));
         wr(OFF_CMP2_CTRL, 8'h08 | 8'(3 - c));
         cyc(1);
         chk({ch2, ch1, sp, rs}, {2'(3 - c), 2'(c), 4'b1101});
         rdc(OFF_CMP1_CTRL, 8'h0C | 8'(c));
      end
      wr(OFF_CMP2_CTRL, 8'h40);
      rdc(OFF_CMP2_CTRL, 8'h00);
      $display("field test done");
   endtask
   task automatic t_invert;
      wr(OFF_CMP1_CTRL, 8'h10);
      rdc(OFF_CMP1_CTRL, 8'h50);
      wr(OFF_SHARED_CTRL, 8'hFF);
      rdc(OFF_SHARED_CTRL, 8'hB0);
      chk({6'h0, rsrc}, 8'h03);
      wr(OFF_SHARED_CTRL, 8'h00);
      $display("invert test done");
   endtask
   task automatic t_change;
      above(4'h1);
      wr(OFF_IRQ_MASK, 8'h01);
      wr(OFF_IRQ_CTRL, 8'h40);
      wr(OFF_CMP1_CTRL, 8'h80);
      cyc(10);
      wr(OFF_IRQ_FLAG, 8'h00);
      rdc(OFF_CMP1_CTRL, 8'hC0);
      cyc(8);
      chk({7'h0, flag[0]}, 8'h00);
      above(4'h0);
      wait_flag();
      cyc(2);
      chk({6'h0, irq, wake}, 8'h01);
      wr(OFF_IRQ_FLAG, 8'h00);
      cyc(8);
      chk({7'h0, flag[0]}, 8'h00);
      rdc(OFF_SHARED_CTRL, 8'h00);
      above(4'h1);
      cyc(10);
      chk({7'h0, flag[0]}, 8'h00);
      rdc(OFF_CMP1_CTRL, 8'hC0);
      wr(OFF_IRQ_CTRL, 8'hC0);
      above(4'h0);
      wait_flag();
      cyc(2);
      chk({6'h0, irq, wake}, 8'h03);
      wr(OFF_IRQ_FLAG, 8'h00);
      $display("change test done");
   endtask
   task automatic t_pin;
      wr(OFF_CMP2_CTRL, 8'hB0);
      cyc(6);
      chk({7'h0, oe[1]}, 8'h00);
      @(posedge clk_in);
      dir <= 2'b01;
      cyc(3);
      chk({6'h0, oe[1], pin[1]}, 8'h03);
      wr(OFF_CMP2_CTRL, 8'h30);
      cyc(3);
      chk({7'h0, oe[1]}, 8'h00);
      $display("pin test done");
   endtask
   task automatic t_port;
      @(posedge clk_in);
      port_pins <= 8'hA5;
      cyc(5);
      rdc(OFF_PORT, 8'h00);
      wr(OFF_ANALOG_SEL, 8'h0F);
      cyc(5);
      rdc(OFF_PORT, 8'hA0);
      wr(4'hF, 8'hFF);
      rdc(4'hF, 8'h00);
      $display("port test done");
   endtask
   initial
   begin
      nrst_in = 1'b0;
      wr_in = 1'b0;
      rd_in = 1'b0;
      addr_in = 4'h0;
      wdata_in = 8'h00;
      port_pins = 8'h00;
      dir = 2'b11;
      pin_above = 4'h0;
      ref_above = 4'hF;
      bad_count = 0;
      check_count = 0;
      repeat (3) @(posedge clk_in);
      nrst_in <= 1'b1;
      t_reset();
      t_fields();
      t_invert();
      t_change();
      t_pin();
      t_port();
      @(posedge clk_in);
      nrst_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      nrst_in <= 1'b1;
      t_reset();
      summarize();
   end
endmodule
`default_nettype wire
